// ---- hw/rri_pkg.sv ----
// package for the return and rotate instruction execution block
package rri_pkg;
  localparam int PC_W = 15;
  localparam int SP_W = 4;
  localparam int DEPTH = 16;
  localparam int GIE_BIT = 7;
  localparam int RET_CYCLES = 2;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] INTERRUPT_CONTROL_REG_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [SP_W-1:0] SP_RST = 4'hF;

  typedef enum logic [2:0] {
    RRI_NOP, RRI_SWRESET, RRI_RETFI, RRI_RETSUB, RRI_RETLIT, RRI_ROTL
  } rri_op_e;

  typedef struct packed {
    rri_op_e op;
    logic [7:0] lit;
    logic [7:0] fval;
    logic [6:0] faddr;
    logic dest;
  } rri_instr_s;

  typedef struct packed {
    logic we;
    logic [6:0] addr;
    logic [7:0] data;
  } rri_fwr_s;
endpackage : rri_pkg

// ---- hw/rri_exec.sv ----
// execution unit for reset, return and rotate-left instructions
`timescale 1ns/1ps
module rri_exec (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic instr_valid,
  input wire rri_pkg::rri_instr_s instr,
  input wire logic push,
  input wire logic [rri_pkg::PC_W-1:0] push_addr,
  output logic busy,
  output logic [rri_pkg::PC_W-1:0] pc,
  output logic [7:0] w_reg,
  output logic carry,
  output logic [7:0] interrupt_control_reg,
  output logic reset_instruction_flag_n,
  output rri_pkg::rri_fwr_s fwr,
  output logic soft_reset_n
);
  import rri_pkg::*;

  // ****************************************
  // state and storage
  // ****************************************
  typedef enum logic {RRI_IDLE, RRI_SECOND} rri_state_e;
  rri_state_e st_r;
  logic [PC_W-1:0] stack_r [DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [PC_W-1:0] pc_r;
  logic [7:0] w_r;
  logic c_r;
  logic [7:0] interrupt_control_reg_r;
  logic ri_n_r;
  logic srst_r;
  logic busy_r;
  logic srst_n_r;
  rri_fwr_s fwr_r;

  // ****************************************
  // decode
  // ****************************************
  wire logic take = instr_valid && st_r == RRI_IDLE && !srst_r;
  wire logic is_ret = take && (instr.op == RRI_RETFI || instr.op == RRI_RETSUB ||
                               instr.op == RRI_RETLIT);
  wire logic is_rot = take && instr.op == RRI_ROTL;
  wire logic is_rst = take && instr.op == RRI_SWRESET;
  wire logic [7:0] rot_val = {instr.fval[6:0], c_r};
  wire logic [PC_W-1:0] top_of_stack = stack_r[sp_r];
  wire logic [SP_W-1:0] sp_pop = sp_r - 4'h1;
  wire logic [SP_W-1:0] sp_push = sp_r + 4'h1;
  // soft reset is held for one cycle and applied as a synchronous branch; core_rst_n is the external reset only
  wire logic core_rst_n = arst_n;

  // ****************************************
  // sequencing
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= RRI_IDLE;
      sp_r <= SP_RST;
      pc_r <= PC_RST;
      w_r <= W_RST;
      c_r <= 1'b0;
      interrupt_control_reg_r <= INTERRUPT_CONTROL_REG_RST;
      srst_r <= 1'b0;
      busy_r <= 1'b0;
      srst_n_r <= 1'b1;
      fwr_r <= '0;
    end else if (srst_r) begin
      // one cycle of synchronous full reset of the core state
      st_r <= RRI_IDLE;
      sp_r <= SP_RST;
      pc_r <= PC_RST;
      w_r <= W_RST;
      c_r <= 1'b0;
      interrupt_control_reg_r <= INTERRUPT_CONTROL_REG_RST;
      srst_r <= 1'b0;
      busy_r <= 1'b0;
      srst_n_r <= 1'b1;
      fwr_r <= '0;
    end else begin
      fwr_r.we <= 1'b0;
      srst_r <= is_rst;
      srst_n_r <= !is_rst;
      busy_r <= is_ret;
      if (st_r == RRI_SECOND) begin
        st_r <= RRI_IDLE;
      end
      if (is_ret) begin
        st_r <= RRI_SECOND;
        pc_r <= top_of_stack;
        sp_r <= sp_pop;
        if (instr.op == RRI_RETFI) begin
          interrupt_control_reg_r[GIE_BIT] <= 1'b1;
        end
        if (instr.op == RRI_RETLIT) begin
          w_r <= instr.lit;
        end
      end else if (push) begin
        sp_r <= sp_push;
      end
      if (is_rot) begin
        c_r <= instr.fval[7];
        if (instr.dest) begin
          fwr_r <= '{we: 1'b1, addr: instr.faddr, data: rot_val};
        end else begin
          w_r <= rot_val;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (push && !is_ret && !srst_r) begin
      stack_r[sp_push] <= push_addr;
    end
  end

  // flag survives the reset it causes; only an external reset sets it back
  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      ri_n_r <= 1'b1;
    end else if (is_rst) begin
      ri_n_r <= 1'b0;
    end
  end

  assign busy = busy_r;
  assign pc = pc_r;
  assign w_reg = w_r;
  assign carry = c_r;
  assign interrupt_control_reg = interrupt_control_reg_r;
  assign reset_instruction_flag_n = ri_n_r;
  assign fwr = fwr_r;
  assign soft_reset_n = srst_n_r;

  // ****************************************
  // checks
  // ****************************************
  property p_rst_follow;
    @(posedge clk) disable iff (!arst_n) is_rst |=> soft_reset_n == 1'b0 ##1 pc == PC_RST;
  endproperty
  a_rst_follow: assert property (p_rst_follow) else $error("soft reset not applied");
  property p_ret_two;
    @(posedge clk) disable iff (!arst_n) (is_ret && !srst_r) |=> busy ##1 !busy;
  endproperty
  a_ret_two: assert property (p_ret_two) else $error("return not two cycles");
  property p_gie;
    @(posedge clk) disable iff (!arst_n)
      (is_ret && !srst_r && instr.op == RRI_RETFI) |=> interrupt_control_reg[GIE_BIT];
  endproperty
  a_gie: assert property (p_gie) else $error("interrupt enable not set");
  property p_ret_pc;
    @(posedge clk) disable iff (!arst_n)
      (is_ret && !srst_r && instr.op == RRI_RETSUB) |=> pc == $past(top_of_stack) && $stable(carry);
  endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return target wrong");
  property p_lit;
    @(posedge clk) disable iff (!arst_n)
      (is_ret && !srst_r && instr.op == RRI_RETLIT) |=> w_reg == $past(instr.lit);
  endproperty
  a_lit: assert property (p_lit) else $error("literal not in working register");
  property p_lit_pc;
    @(posedge clk) disable iff (!arst_n)
      (is_ret && !srst_r && instr.op == RRI_RETLIT) |=> pc == $past(top_of_stack) ##1 !busy;
  endproperty
  a_lit_pc: assert property (p_lit_pc) else $error("literal return pc wrong");
  property p_rot;
    @(posedge clk) disable iff (!arst_n)
      (is_rot && !srst_r) |=> carry == $past(instr.fval[7]);
  endproperty
  a_rot: assert property (p_rot) else $error("carry not from msb");
  property p_dest;
    @(posedge clk) disable iff (!arst_n)
      (is_rot && !srst_r && instr.dest) |=> fwr.we && fwr.data == $past(rot_val);
  endproperty
  a_dest: assert property (p_dest) else $error("rotate result not written back");
  property p_pop;
    @(posedge clk) disable iff (!arst_n) (is_ret && !srst_r) |=> sp_r == $past(sp_r) - 4'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("stack pointer not popped");
  c_retfi: cover property (@(posedge clk) is_ret && instr.op == RRI_RETFI);
  c_rot_w: cover property (@(posedge clk) is_rot && !instr.dest);
  c_reset: cover property (@(posedge clk) is_rst);
  c_retlit: cover property (@(posedge clk) is_ret && instr.op == RRI_RETLIT);
  c_rot_f: cover property (@(posedge clk) is_rot && instr.dest);
  property p_rot_w;
    @(posedge clk) disable iff (!arst_n)
      (is_rot && !instr.dest) |=> w_reg == $past(rot_val) && !fwr.we;
  endproperty
  a_rot_w: assert property (p_rot_w) else $error("rotate to w wrong");
  property p_ret_carry;
    @(posedge clk) disable iff (!arst_n)
      is_ret |=> $stable(carry);
  endproperty
  a_ret_carry: assert property (p_ret_carry) else $error("return touched carry");
  property p_gie_keep;
    @(posedge clk) disable iff (!arst_n)
      (!srst_r && !(is_ret && instr.op == RRI_RETFI)) |=> $stable(interrupt_control_reg);
  endproperty
  a_gie_keep: assert property (p_gie_keep) else $error("interrupt control changed");
  property p_srst_once;
    @(posedge clk) disable iff (!arst_n)
      !soft_reset_n |=> soft_reset_n;
  endproperty
  a_srst_once: assert property (p_srst_once) else $error("soft reset too long");
  property p_flag;
    @(posedge clk) disable iff (!arst_n)
      !reset_instruction_flag_n |=> !reset_instruction_flag_n;
  endproperty
  a_flag: assert property (p_flag) else $error("reset flag lost");
  property p_no_fwr;
    @(posedge clk) disable iff (!arst_n)
      !(is_rot && instr.dest) |=> !fwr.we;
  endproperty
  a_no_fwr: assert property (p_no_fwr) else $error("stray file write");
  property p_push;
    @(posedge clk) disable iff (!arst_n)
      (push && !is_ret && !srst_r) |=> sp_r == $past(sp_r) + 4'h1;
  endproperty
  a_push: assert property (p_push) else $error("stack pointer not pushed");
  property p_nop;
    @(posedge clk) disable iff (!arst_n)
      (take && instr.op == RRI_NOP) |=> $stable(pc) && $stable(w_reg) && $stable(carry);
  endproperty
  a_nop: assert property (p_nop) else $error("idle opcode changed state");
endmodule : rri_exec

// ---- bench/tb_top.sv ----
// self-checking bench for the return and rotate execution unit
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, a); end end
module tb_top;
  import rri_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic instr_valid = 1'b0;
  rri_instr_s instr = '0;
  logic push = 1'b0;
  logic [PC_W-1:0] push_addr = '0;
  logic busy, carry, reset_instruction_flag_n, soft_reset_n;
  logic [PC_W-1:0] pc;
  logic [7:0] w_reg, interrupt_control_reg;
  rri_fwr_s fwr;
  int fail_count = 0;
  int n_checks = 0;
  always #25 clk = ~clk;
  rri_exec DUT (.clk(clk), .arst_n(arst_n), .instr_valid(instr_valid), .instr(instr),
    .push(push), .push_addr(push_addr), .busy(busy), .pc(pc), .w_reg(w_reg), .carry(carry),
    .interrupt_control_reg(interrupt_control_reg), .fwr(fwr), .soft_reset_n(soft_reset_n),
    .reset_instruction_flag_n(reset_instruction_flag_n));
  // ****************
  // drivers
  // ****************
  task automatic issue(input rri_op_e op, input logic [7:0] lit, input logic [7:0] fv,
                       input logic d);
    @(posedge clk);
    instr_valid <= 1'b1;
    instr <= '{op: op, lit: lit, fval: fv, faddr: 7'h2A, dest: d};
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask : issue
  task automatic do_push(input logic [PC_W-1:0] a);
    @(posedge clk);
    push <= 1'b1;
    push_addr <= a;
    @(posedge clk);
    push <= 1'b0;
  endtask : do_push
  // ****************
  // scenarios
  // ****************
  task automatic t_rotate;
    issue(RRI_ROTL, 8'h00, 8'hE6, 1'b0);
    `CHK("w", 8'hCC, w_reg)
    `CHK("carry", 1'b1, carry)
    `CHK("fwr_we", 1'b0, fwr.we)
    issue(RRI_NOP, 8'h11, 8'hFF, 1'b1);
    `CHK("w", 8'hCC, w_reg)
    `CHK("carry", 1'b1, carry)
    `CHK("fwr_we", 1'b0, fwr.we)
    issue(RRI_ROTL, 8'h00, 8'h35, 1'b1);
    `CHK("fwr_data", 8'h6B, fwr.data)
    `CHK("fwr_we", 1'b1, fwr.we)
    `CHK("fwr_addr", 7'h2A, fwr.addr)
    `CHK("carry", 1'b0, carry)
    `CHK("w", 8'hCC, w_reg)
  endtask : t_rotate
  task automatic t_returns;
    do_push(15'h1234);
    do_push(15'h0ABC);
    issue(RRI_RETLIT, 8'hFF, 8'h00, 1'b0);
    `CHK("pc", 15'h0ABC, pc)
    `CHK("w", 8'hFF, w_reg)
    `CHK("busy", 1'b1, busy)
    @(posedge clk);
    #1;
    `CHK("busy", 1'b0, busy)
    issue(RRI_RETFI, 8'h00, 8'h00, 1'b0);
    `CHK("pc", 15'h1234, pc)
    `CHK("interrupt_control_reg", 8'h80, interrupt_control_reg)
    `CHK("busy", 1'b1, busy)
    @(posedge clk);
    do_push(15'h0055);
    issue(RRI_ROTL, 8'h00, 8'h80, 1'b0);
    issue(RRI_RETSUB, 8'h00, 8'h00, 1'b0);
    `CHK("pc", 15'h0055, pc)
    `CHK("carry", 1'b1, carry)
    `CHK("busy", 1'b1, busy)
    @(posedge clk);
  endtask : t_returns
  task automatic t_swreset;
    issue(RRI_SWRESET, 8'h00, 8'h00, 1'b0);
    `CHK("soft_reset_n", 1'b0, soft_reset_n)
    @(posedge clk);
    #1;
    `CHK("pc", 15'h0000, pc)
    `CHK("w", 8'h00, w_reg)
    `CHK("interrupt_control_reg", 8'h00, interrupt_control_reg)
    `CHK("flag_n", 1'b0, reset_instruction_flag_n)
    `CHK("carry", 1'b0, carry)
    `CHK("soft_reset_n", 1'b1, soft_reset_n)
  endtask : t_swreset
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    t_rotate();
    t_returns();
    t_swreset();
    print_verdict();
  end
  // whole run is under a hundred cycles, so this leaves wide margin
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule : tb_top
